// File: csfp_dev_end.sv
// Codec end of the frame port and its converter word FIFO
// Overview of operation
// - Input bits sampled on clock falls in frame
// - Output bits launched on clock rises in frame
// - Data output released while frame sync high
// - Shifting starts when frame sync falls
// - Master makes frame sync, slave receives it
// - Delayed frame sync, same width, for slaves
// - Flag shows secondary interval when source zero
// - Flag shows static value when source one
// - Partner drives secondary request, low if unused
// - Config writes via serial input, idle high
// - Event mode takes event input, low if unused
// - Two mode pins select frame-sync mode
// - Master clock 256 or 512 per frame
// - Master select high master, low slave
`include "csfp_consts.svh"

////////////////////////////////////////////////////////////////////////////
module csfp_fifo
   import csfp_pkg::*;
#(
   parameter int WIDTH = `CSFP_WORD_BITS,
   parameter int DEPTH = `CSFP_FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic inReady_reg;
   logic outValid_reg;

   // Handshakes and occupancy
   wire doWrite = inValid & inReady_reg;
   wire doRead = outValid_reg & outReady;
   assign count_next = count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
   assign outData = mem[rdPtr_reg];
   assign inReady = inReady_reg;
   assign outValid = outValid_reg;

   // Storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (ce && doWrite)
         mem[wrPtr_reg] <= inData;
   end

   // Pointers wrap, depth is a power of two
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
         inReady_reg <= 1'b1;
         outValid_reg <= 1'b0;
      end
      else if (ce)
      begin
         wrPtr_reg <= wrPtr_reg + AW'(doWrite);
         rdPtr_reg <= rdPtr_reg + AW'(doRead);
         count_reg <= count_next;
         inReady_reg <= count_next != (AW+1)'(DEPTH);
         outValid_reg <= count_next != '0;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module csfp_dev_end
   import csfp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   csfp_link_if.dev link,
   input wire logic [15:0] adcData,
   input wire logic adcValid,
   output logic adcReady,
   input wire logic [3:0] cascadeCount,
   input wire logic flagSourceSelect,
   input wire logic flagStaticValue,
   output logic [15:0] dacData,
   output logic dacValid,
   output logic [15:0] cfgWord,
   output logic cfgValid,
   output logic eventMode
);
   logic [8:0] s1_reg;
   logic [8:0] s2_reg;
   logic [8:0] s3_reg;
   logic [8:0] lvl_reg;
   logic [8:0] lvlD_reg;
   logic [4:0] halfCnt_reg;
   logic sclkOut_reg;
   logic master_reg;
   logic [9:0] posCnt_reg;
   logic frmOut_reg;
   logic dlyOut_reg;
   logic [15:0] txShift_reg;
   logic doutBit_reg;
   logic doutOe_reg;
   logic [15:0] rxShift_reg;
   logic [4:0] rxCnt_reg;
   logic [15:0] dacData_reg;
   logic dacValid_reg;
   logic reqPend_reg;
   logic secFrame_reg;
   logic flag_reg;
   csfp_cfg_type cfgState_reg;
   logic [4:0] cfgCnt_reg;
   logic [15:0] cfgShift_reg;
   logic [15:0] cfgWord_reg;
   logic cfgValid_reg;
   logic eventMode_reg;
   logic [15:0] fifoData;
   logic fifoValid;

   ////////////////////////////////////////////////////////////////////////
   // Pins from outside the clock domain, three stages each
   wire [8:0] pinRaw = {link.masterSelect, link.frameModeSelHi,
      link.frameModeSelLo, link.eventMonitorSerialIn,
      link.directConfigSerialIn, link.secondaryCommRequest,
      link.frameSync, link.din, link.sclk};

   localparam logic [8:0] PIN_IDLE = `CSFP_DEV_PIN_IDLE;

   for (genvar i = 0; i < 9; i++)
   begin : gSync
      // Level accepted once stages two and three agree
      always_ff @(posedge clk)
      begin
         if (rst)
         begin
            s1_reg[i] <= PIN_IDLE[i];
            s2_reg[i] <= PIN_IDLE[i];
            s3_reg[i] <= PIN_IDLE[i];
            lvl_reg[i] <= PIN_IDLE[i];
            lvlD_reg[i] <= PIN_IDLE[i];
         end
         else if (ce)
         begin
            s1_reg[i] <= pinRaw[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (s2_reg[i] == s3_reg[i])
               lvl_reg[i] <= s3_reg[i];
            lvlD_reg[i] <= lvl_reg[i];
         end
      end
   end

   // Named levels and their delayed copies
   wire sMs, sModeHi, sModeLo, sEvt, sCfg, sReq, sFrm, sDin, sSclk;
   wire dMs, dModeHi, dModeLo, dEvt, dCfg, dReq, dFrm, dDin, dSclk;
   assign {sMs, sModeHi, sModeLo, sEvt, sCfg, sReq, sFrm, sDin, sSclk} =
      lvl_reg;
   assign {dMs, dModeHi, dModeLo, dEvt, dCfg, dReq, dFrm, dDin, dSclk} =
      lvlD_reg;

   ////////////////////////////////////////////////////////////////////////
   // Shift clock source and edges
   wire master = sMs;
   wire halfDone = halfCnt_reg == `CSFP_HALF_LAST;
   wire sckRise = master ? (halfDone & ~sclkOut_reg) : (sSclk & ~dSclk);
   wire sckFall = master ? (halfDone & sclkOut_reg) : (~sSclk & dSclk);
   wire [9:0] frameLen = (cascadeCount > `CSFP_CASCADE_SHORT_MAX) ?
      `CSFP_FRAME_LONG : `CSFP_FRAME_SHORT;
   wire posLast = posCnt_reg == frameLen - 10'h001;
   wire [9:0] posInc = posLast ? 10'h000 : posCnt_reg + 10'h001;
   wire frmFall = master ? (sckRise & posLast) : (~sFrm & dFrm);
   wire frmEff = master ? frmOut_reg : sFrm;
   wire inFrame = ~frmEff;
   wire modeEvent = {sModeHi, sModeLo} == `CSFP_MODE_EVENT;
   wire capBit = modeEvent ? sEvt : sDin;
   wire reqRise = sReq & ~dReq;

   // Divider makes the shift clock as master
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         halfCnt_reg <= 5'h00;
         sclkOut_reg <= 1'b0;
         master_reg <= 1'b0;
      end
      else if (ce)
      begin
         master_reg <= master;
         halfCnt_reg <= (!master || halfDone) ? 5'h00 : halfCnt_reg + 5'h01;
         if (master && halfDone)
            sclkOut_reg <= ~sclkOut_reg;
      end
   end

   // Frame position, own frame sync and delayed copy
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         posCnt_reg <= `CSFP_FRAME_LONG - 10'h001;
         frmOut_reg <= 1'b1;
         dlyOut_reg <= 1'b1;
      end
      else if (ce)
      begin
         if (!master && frmFall)
            posCnt_reg <= 10'h000;
         else if (sckRise && (master || !posLast))
            posCnt_reg <= posInc;
         if (!master)
            frmOut_reg <= 1'b1;
         else if (sckRise)
            frmOut_reg <= !(posInc < `CSFP_SLOT_BITS);
         dlyOut_reg <= !(posCnt_reg >= `CSFP_SLOT_BITS &&
            posCnt_reg < `CSFP_DLY_END);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter words wait here for the next frame
   csfp_fifo #(
      .WIDTH(`CSFP_WORD_BITS),
      .DEPTH(`CSFP_FIFO_DEPTH)
   ) csfp_fifo_inst (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .inData(adcData),
      .inValid(adcValid),
      .inReady(adcReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(frmFall)
   );

   wire [15:0] txWord = fifoValid ? fifoData : 16'h0000;

   // Output shifter, first bit at the frame sync fall
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         txShift_reg <= 16'h0000;
         doutBit_reg <= 1'b1;
         doutOe_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (frmFall)
         begin
            doutBit_reg <= txWord[15];
            txShift_reg <= {txWord[14:0], 1'b0};
         end
         else if (sckRise && inFrame)
         begin
            doutBit_reg <= txShift_reg[15];
            txShift_reg <= {txShift_reg[14:0], 1'b0};
         end
         doutOe_reg <= inFrame | frmFall;
      end
   end

   // Input shifter, one word per frame
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rxShift_reg <= 16'h0000;
         rxCnt_reg <= 5'h00;
         dacData_reg <= 16'h0000;
         dacValid_reg <= 1'b0;
      end
      else if (ce)
      begin
         dacValid_reg <= 1'b0;
         if (frmFall)
            rxCnt_reg <= 5'h00;
         else if (sckFall && inFrame && rxCnt_reg <= `CSFP_BIT_LAST)
         begin
            rxShift_reg <= {rxShift_reg[14:0], capBit};
            rxCnt_reg <= rxCnt_reg + 5'h01;
            if (rxCnt_reg == `CSFP_BIT_LAST)
            begin
               dacData_reg <= {rxShift_reg[14:0], capBit};
               dacValid_reg <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Secondary request marks the next frame, a new request wins
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reqPend_reg <= 1'b0;
         secFrame_reg <= 1'b0;
         flag_reg <= 1'b0;
         eventMode_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (frmFall)
         begin
            secFrame_reg <= reqPend_reg;
            reqPend_reg <= reqRise;
         end
         else if (reqRise)
            reqPend_reg <= 1'b1;
         flag_reg <= flagSourceSelect ? flagStaticValue :
            secFrame_reg;
         eventMode_reg <= modeEvent;
      end
   end

   // Configuration input: start bit low then sixteen bits
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfgState_reg <= CFG_IDLE;
         cfgCnt_reg <= 5'h00;
         cfgShift_reg <= 16'h0000;
         cfgWord_reg <= 16'h0000;
         cfgValid_reg <= 1'b0;
      end
      else if (ce)
      begin
         cfgValid_reg <= 1'b0;
         if (sckFall)
         begin
            case (cfgState_reg)
               CFG_IDLE:
               begin
                  cfgCnt_reg <= 5'h00;
                  if (!sCfg)
                     cfgState_reg <= CFG_SHIFT;
               end
               CFG_SHIFT:
               begin
                  cfgShift_reg <= {cfgShift_reg[14:0], sCfg};
                  cfgCnt_reg <= cfgCnt_reg + 5'h01;
                  if (cfgCnt_reg == `CSFP_BIT_LAST)
                  begin
                     cfgWord_reg <= {cfgShift_reg[14:0], sCfg};
                     cfgValid_reg <= 1'b1;
                     cfgState_reg <= CFG_IDLE;
                  end
               end
               default: cfgState_reg <= CFG_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins and user outputs, all from flip-flops
   assign link.devSclkOut = sclkOut_reg;
   assign link.devSclkOe = master_reg;
   assign link.devFrmOut = frmOut_reg;
   assign link.devFrmOe = master_reg;
   assign link.devDoutOut = doutBit_reg;
   assign link.devDoutOe = doutOe_reg;
   assign link.delayedFrameSyncOut = dlyOut_reg;
   assign link.flagPin = flag_reg;
   assign dacData = dacData_reg;
   assign dacValid = dacValid_reg;
   assign cfgWord = cfgWord_reg;
   assign cfgValid = cfgValid_reg;
   assign eventMode = eventMode_reg;
endmodule

// File: csfp_consts.svh
// Constants shared by both ends of the codec frame port
`ifndef CSFP_CONSTS_SVH
`define CSFP_CONSTS_SVH

// Word and slot sizes
`define CSFP_WORD_BITS 16
`define CSFP_SLOT_BITS 10'h010
`define CSFP_DLY_END 10'h020
`define CSFP_BIT_LAST 5'h0F
`define CSFP_CFG_FRAME 5'h11

// Shift clock from the system clock
`define CSFP_CLK_NS 8
`define CSFP_SCLK_NS 160
`define CSFP_SCLK_HALF ((`CSFP_SCLK_NS / `CSFP_CLK_NS) / 2)
`define CSFP_HALF_LAST 5'(`CSFP_SCLK_HALF - 1)

// Frame lengths in shift clocks and the cascade limit
`define CSFP_FRAME_SHORT 10'h100
`define CSFP_FRAME_LONG 10'h200
`define CSFP_CASCADE_SHORT_MAX 4'h4

// Frame mode select code for event monitoring
`define CSFP_MODE_EVENT 2'h3

// Buffer depth in words
`define CSFP_FIFO_DEPTH 16

// Idle levels of the synchronised pins
`define CSFP_DEV_PIN_IDLE 9'h014
`define CSFP_HOST_PIN_IDLE 5'h16

`endif

// File: csfp_pkg.sv
// Types shared by both ends of the codec frame port
package csfp_pkg;

   // Serial configuration shifter states
   typedef enum logic {CFG_IDLE, CFG_SHIFT} csfp_cfg_type;

endpackage

// File: csfp_link_if.sv
// Pin-level link between the codec end and the DSP end
interface csfp_link_if;

   // Drives of the two-way pins and of the three-state data output
   logic devSclkOut;
   logic devSclkOe;
   logic hostSclkOut;
   logic hostSclkOe;
   logic devFrmOut;
   logic devFrmOe;
   logic hostFrmOut;
   logic hostFrmOe;
   logic devDoutOut;
   logic devDoutOe;

   // One-way pins
   logic din;
   logic delayedFrameSyncOut;
   logic flagPin;
   logic secondaryCommRequest;
   logic directConfigSerialIn;
   logic eventMonitorSerialIn;
   logic frameModeSelLo;
   logic frameModeSelHi;
   logic masterSelect;

   // Wire levels from the enables, idle levels where nobody drives
   wire sclk = devSclkOe ? devSclkOut : (hostSclkOe ? hostSclkOut : 1'b0);
   wire frameSync = devFrmOe ? devFrmOut : (hostFrmOe ? hostFrmOut : 1'b1);
   wire dout = devDoutOe ? devDoutOut : 1'b1;

   modport dev (
      input sclk, frameSync, din, secondaryCommRequest,
      input directConfigSerialIn, eventMonitorSerialIn,
      input frameModeSelLo, frameModeSelHi, masterSelect,
      output devSclkOut, devSclkOe, devFrmOut, devFrmOe,
      output devDoutOut, devDoutOe, delayedFrameSyncOut, flagPin
   );

   modport host (
      input sclk, frameSync, dout, delayedFrameSyncOut, flagPin,
      output hostSclkOut, hostSclkOe, hostFrmOut, hostFrmOe, din,
      output secondaryCommRequest, directConfigSerialIn,
      output eventMonitorSerialIn, frameModeSelLo, frameModeSelHi,
      output masterSelect
   );

endinterface

// File: csfp_host_end.sv
// DSP end of the codec frame port
`include "csfp_consts.svh"

module csfp_host_end
   import csfp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   csfp_link_if.host link,
   input wire logic deviceMaster,
   input wire logic [1:0] modeSel,
   input wire logic [15:0] txData,
   input wire logic txValid,
   output logic txReady,
   output logic [15:0] rxData,
   output logic rxValid,
   input wire logic secRequest,
   input wire logic [15:0] cfgData,
   input wire logic cfgStart,
   output logic cfgBusy,
   input wire logic eventIn,
   output logic flagLevel,
   output logic dlyLevel
);
   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   logic [4:0] s3_reg;
   logic [4:0] lvl_reg;
   logic [4:0] lvlD_reg;
   logic devMaster_reg;
   logic [1:0] mode_reg;
   logic req_reg;
   logic evt_reg;
   logic [4:0] halfCnt_reg;
   logic sclkOut_reg;
   logic [9:0] posCnt_reg;
   logic frmOut_reg;
   logic [15:0] hold_reg;
   logic txReady_reg;
   logic [15:0] txShift_reg;
   logic din_reg;
   logic [15:0] rxShift_reg;
   logic [4:0] rxCnt_reg;
   logic [15:0] rxData_reg;
   logic rxValid_reg;
   csfp_cfg_type cfgState_reg;
   logic [16:0] cfgShift_reg;
   logic [4:0] cfgCnt_reg;
   logic cfgOut_reg;

   // Device pins pass three stages each
   wire [4:0] pinRaw = {link.delayedFrameSyncOut, link.flagPin, link.dout,
      link.frameSync, link.sclk};

   localparam logic [4:0] PIN_IDLE = `CSFP_HOST_PIN_IDLE;

   for (genvar i = 0; i < 5; i++)
   begin : gSync
      // Level accepted once stages two and three agree
      always_ff @(posedge clk)
      begin
         if (rst)
         begin
            s1_reg[i] <= PIN_IDLE[i];
            s2_reg[i] <= PIN_IDLE[i];
            s3_reg[i] <= PIN_IDLE[i];
            lvl_reg[i] <= PIN_IDLE[i];
            lvlD_reg[i] <= PIN_IDLE[i];
         end
         else if (ce)
         begin
            s1_reg[i] <= pinRaw[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (s2_reg[i] == s3_reg[i])
               lvl_reg[i] <= s3_reg[i];
            lvlD_reg[i] <= lvl_reg[i];
         end
      end
   end

   wire sDly, sFlag, sDout, sFrm, sSclk;
   wire dDly, dFlag, dDout, dFrm, dSclk;
   assign {sDly, sFlag, sDout, sFrm, sSclk} = lvl_reg;
   assign {dDly, dFlag, dDout, dFrm, dSclk} = lvlD_reg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and frame source when the codec is a slave
   wire mine = ~devMaster_reg;
   wire halfDone = halfCnt_reg == `CSFP_HALF_LAST;
   wire sckRise = mine ? (halfDone & ~sclkOut_reg) : (sSclk & ~dSclk);
   wire sckFall = mine ? (halfDone & sclkOut_reg) : (~sSclk & dSclk);
   wire posLast = posCnt_reg == `CSFP_FRAME_SHORT - 10'h001;
   wire [9:0] posInc = posLast ? 10'h000 : posCnt_reg + 10'h001;
   wire frmFall = mine ? (sckRise & posLast) : (~sFrm & dFrm);
   wire inFrame = mine ? ~frmOut_reg : ~sFrm;
   wire [15:0] txWord = txReady_reg ? 16'h0000 : hold_reg;

   // Straps, request and event pins
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         devMaster_reg <= 1'b0;
         mode_reg <= 2'h0;
         req_reg <= 1'b0;
         evt_reg <= 1'b0;
      end
      else if (ce)
      begin
         devMaster_reg <= deviceMaster;
         mode_reg <= modeSel;
         req_reg <= secRequest;
         evt_reg <= eventIn;
      end
   end

   // Divider and frame position
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         halfCnt_reg <= 5'h00;
         sclkOut_reg <= 1'b0;
         posCnt_reg <= `CSFP_FRAME_SHORT - 10'h001;
         frmOut_reg <= 1'b1;
      end
      else if (ce)
      begin
         halfCnt_reg <= (!mine || halfDone) ? 5'h00 : halfCnt_reg + 5'h01;
         if (mine && halfDone)
            sclkOut_reg <= ~sclkOut_reg;
         if (mine && sckRise)
         begin
            posCnt_reg <= posInc;
            frmOut_reg <= !(posInc < `CSFP_SLOT_BITS);
         end
         else if (!mine)
            frmOut_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One-word hold and data shifters
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hold_reg <= 16'h0000;
         txReady_reg <= 1'b1;
         txShift_reg <= 16'h0000;
         din_reg <= 1'b0;
         rxShift_reg <= 16'h0000;
         rxCnt_reg <= 5'h00;
         rxData_reg <= 16'h0000;
         rxValid_reg <= 1'b0;
      end
      else if (ce)
      begin
         rxValid_reg <= 1'b0;
         if (frmFall)
         begin
            din_reg <= txWord[15];
            txShift_reg <= {txWord[14:0], 1'b0};
            txReady_reg <= 1'b1;
            rxCnt_reg <= 5'h00;
         end
         else
         begin
            if (txValid && txReady_reg)
            begin
               hold_reg <= txData;
               txReady_reg <= 1'b0;
            end
            if (sckRise && inFrame)
            begin
               din_reg <= txShift_reg[15];
               txShift_reg <= {txShift_reg[14:0], 1'b0};
            end
            if (sckFall && inFrame && rxCnt_reg <= `CSFP_BIT_LAST)
            begin
               rxShift_reg <= {rxShift_reg[14:0], sDout};
               rxCnt_reg <= rxCnt_reg + 5'h01;
               if (rxCnt_reg == `CSFP_BIT_LAST)
               begin
                  rxData_reg <= {rxShift_reg[14:0], sDout};
                  rxValid_reg <= 1'b1;
               end
            end
         end
      end
   end

   // Configuration sender: start bit, sixteen bits, then idle high
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfgState_reg <= CFG_IDLE;
         cfgShift_reg <= 17'h1FFFF;
         cfgCnt_reg <= 5'h00;
         cfgOut_reg <= 1'b1;
      end
      else if (ce)
      begin
         case (cfgState_reg)
            CFG_IDLE:
            begin
               if (sckRise)
                  cfgOut_reg <= 1'b1;
               if (cfgStart)
               begin
                  cfgShift_reg <= {1'b0, cfgData};
                  cfgCnt_reg <= `CSFP_CFG_FRAME;
                  cfgState_reg <= CFG_SHIFT;
               end
            end
            CFG_SHIFT:
            begin
               if (sckRise)
               begin
                  cfgOut_reg <= cfgShift_reg[16];
                  cfgShift_reg <= {cfgShift_reg[15:0], 1'b1};
                  cfgCnt_reg <= cfgCnt_reg - 5'h01;
                  if (cfgCnt_reg == 5'h01)
                     cfgState_reg <= CFG_IDLE;
               end
            end
            default: cfgState_reg <= CFG_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins and user outputs, all from flip-flops
   assign link.hostSclkOut = sclkOut_reg;
   assign link.hostSclkOe = ~devMaster_reg;
   assign link.hostFrmOut = frmOut_reg;
   assign link.hostFrmOe = ~devMaster_reg;
   assign link.din = din_reg;
   assign link.secondaryCommRequest = req_reg;
   assign link.directConfigSerialIn = cfgOut_reg;
   assign link.eventMonitorSerialIn = evt_reg;
   assign link.frameModeSelLo = mode_reg[0];
   assign link.frameModeSelHi = mode_reg[1];
   assign link.masterSelect = devMaster_reg;
   assign txReady = txReady_reg;
   assign rxData = rxData_reg;
   assign rxValid = rxValid_reg;
   assign cfgBusy = cfgState_reg == CFG_SHIFT;
   assign flagLevel = sFlag;
   assign dlyLevel = sDly;
endmodule

// File: csfp_sva.sv
// Link assertions for the codec frame port
module csfp_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic frameSync,
   input wire logic masterSelect,
   input wire logic devSclkOe,
   input wire logic hostSclkOe,
   input wire logic devFrmOe,
   input wire logic hostFrmOe,
   input wire logic devDoutOe,
   input wire logic delayedFrameSyncOut
);
   logic [9:0] fsLow_reg;
   logic [9:0] dlLow_reg;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // Low time of both frame syncs
   always_ff @(posedge clk)
   begin
      fsLow_reg <= frameSync ? 10'h000 : fsLow_reg + 10'h001;
      dlLow_reg <= delayedFrameSyncOut ? 10'h000 : dlLow_reg + 10'h001;
   end
   ////////////////////
   // Delayed sync starts as the slot ends
   sequence dlyOn;
      ##[0:25] !delayedFrameSyncOut;
   endsequence
   chk_dout_idle: assert property (
      frameSync && $past(frameSync, 8) |-> !devDoutOe) else $error("dout");
   chk_dout_frame: assert property (
      !frameSync && !$past(frameSync, 8) |-> devDoutOe) else $error("dout");
   chk_sclk_one: assert property (
      !(devSclkOe && hostSclkOe)) else $error("sclk drivers");
   chk_frame_one: assert property (
      !(devFrmOe && hostFrmOe)) else $error("frame drivers");
   chk_role_master: assert property (
      masterSelect && $past(masterSelect, 12) |-> devSclkOe)
      else $error("codec not master");
   chk_role_slave: assert property (
      !masterSelect && !$past(masterSelect, 12) |-> !devSclkOe)
      else $error("codec not slave");
   chk_frame_width: assert property (
      $rose(frameSync) |-> fsLow_reg inside {[318:322]})
      else $error("frame width");
   chk_delay_width: assert property (
      $rose(delayedFrameSyncOut) |-> dlLow_reg inside {[316:324]})
      else $error("delayed width");
   chk_delay_start: assert property (
      $rose(frameSync) |-> dlyOn) else $error("delayed start");
endmodule

// File: tb_top.sv
// Testbench joining both ends of the codec frame port
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic adcValid = 1'b0, txValid = 1'b0, cfgStart = 1'b0;
   logic deviceMaster = 1'b0, secRequest = 1'b0, eventIn = 1'b0;
   logic flagSourceSelect = 1'b0, flagStaticValue = 1'b0;
   logic [1:0] modeSel = 2'h0;
   logic [3:0] cascadeCount = 4'h0;
   logic [15:0] adcData = 16'h0000, txData = 16'h0000;
   logic [15:0] cfgData = 16'h0000, dacData, cfgWord, rxData, dacSeen;
   logic adcReady, dacValid, cfgValid, eventMode, txReady, rxValid;
   logic cfgBusy, flagLevel, dlyLevel;
   int error_cnt = 0, cmp_count = 0, cycCnt = 0;
   csfp_link_if link ();
   csfp_dev_end csfp_dev_end_inst (.clk, .rst, .ce, .link, .adcData,
      .adcValid, .adcReady, .cascadeCount, .flagSourceSelect,
      .flagStaticValue, .dacData, .dacValid, .cfgWord, .cfgValid,
      .eventMode);
   csfp_host_end csfp_host_end_inst (.clk, .rst, .ce, .link,
      .deviceMaster, .modeSel, .txData, .txValid, .txReady, .rxData,
      .rxValid, .secRequest, .cfgData, .cfgStart, .cfgBusy, .eventIn,
      .flagLevel, .dlyLevel);
   csfp_sva csfp_sva_inst (.clk, .rst, .frameSync(link.frameSync),
      .masterSelect(link.masterSelect), .devSclkOe(link.devSclkOe),
      .hostSclkOe(link.hostSclkOe), .devFrmOe(link.devFrmOe),
      .hostFrmOe(link.hostFrmOe), .devDoutOe(link.devDoutOe),
      .delayedFrameSyncOut(link.delayedFrameSyncOut));
   // System clock
   initial
      forever #4 clk = ~clk;
   // Watchdog and codec word capture
   always @(posedge clk)
   begin
      cycCnt <= cycCnt + 1;
      if (dacValid === 1'b1)
         dacSeen <= dacData;
      if (cycCnt == 90000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   ////////////////////
   // Compare and count
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Waits, each ending at the drive delay
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrx();
      @(posedge rxValid);
      #1;
   endtask
   task automatic wfs();
      @(negedge link.frameSync);
      #1;
   endtask
   // One word each way, then the frame period
   task automatic t_xfer(logic m, logic [3:0] c, logic [31:0] p);
      realtime t0;
      wrx();
      tick(20);
      deviceMaster = m;
      cascadeCount = c;
      adcData = {c, 11'h35A, m};
      txData = ~{c, 11'h35A, m};
      adcValid = 1'b1;
      txValid = 1'b1;
      tick(1);
      adcValid = 1'b0;
      txValid = 1'b0;
      chk("txReady", txReady, 1'b0);
      wfs();
      t0 = $realtime;
      wrx();
      chk("rxData", rxData, adcData);
      tick(40);
      chk("dacData", dacSeen, txData);
      chk("dlyLevel", dlyLevel, 1'b0);
      wfs();
      chk("period", int'(($realtime - t0) / 8), p);
      $display("t_xfer done");
   endtask
   // Static flag, then a requested secondary frame
   task automatic t_flag();
      flagSourceSelect = 1'b1;
      flagStaticValue = 1'b1;
      tick(10);
      chk("flagLevel", flagLevel, 1'b1);
      flagStaticValue = 1'b0;
      tick(10);
      chk("flagPin", link.flagPin, 1'b0);
      flagSourceSelect = 1'b0;
      wfs();
      secRequest = 1'b1;
      wfs();
      tick(30);
      chk("flagPin", link.flagPin, 1'b1);
      secRequest = 1'b0;
      wfs();
      tick(30);
      chk("flagPin", link.flagPin, 1'b0);
      $display("t_flag done");
   endtask
   // Event mode takes the event input
   task automatic t_event();
      modeSel = 2'h3;
      eventIn = 1'b1;
      wrx();
      wrx();
      tick(40);
      chk("eventMode", eventMode, 1'b1);
      chk("dacData", dacSeen, 16'hFFFF);
      modeSel = 2'h0;
      eventIn = 1'b0;
      tick(20);
      chk("eventMode", eventMode, 1'b0);
      $display("t_event done");
   endtask
   // Word over the configuration line
   task automatic t_cfg();
      chk("cfgIdle", link.directConfigSerialIn, 1'b1);
      cfgData = 16'hB24D;
      cfgStart = 1'b1;
      tick(1);
      cfgStart = 1'b0;
      chk("cfgBusy", cfgBusy, 1'b1);
      @(posedge cfgValid);
      #1;
      chk("cfgWord", cfgWord, 16'hB24D);
      chk("cfgBusy", cfgBusy, 1'b0);
      $display("t_cfg done");
   endtask
   // Reset, then each scenario in turn
   initial
   begin
      tick(2);
      rst = 1'b0;
      t_xfer(1'b0, 4'h0, 32'h1400);
      t_xfer(1'b1, 4'h0, 32'h1400);
      t_flag();
      t_event();
      t_cfg();
      t_xfer(1'b1, 4'h5, 32'h2800);
      stop_test();
   end
endmodule
